// [rtl/reset_cause_and_debug_reset.sv]
// Reset-cause status, watchdog service, debug forced reset, write-once options.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Keep a read-only status register naming the source of the latest reset.
// - A debug forced reset leaves every cause flag cleared.
// - With watchdog on, a status write other than 0x55 or 0xaa resets.
// - Writing 0x55 then 0xaa clears the watchdog, flags untouched.
// - Power-on sets power-on and low-voltage flags, clears the rest.
// - Enabled low-voltage trip sets its flag, keeps power-on, clears others.
// - Other resets set flags of active sources, clear power-on and low-voltage.
// - A low level on the reset pin sets the pin flag, bit 6.
// - Watchdog timeout sets bit 5; no watchdog reset while disabled.
// - Illegal opcode, disabled stop or disabled background sets bit 4.
// - Access to an unimplemented address sets bit 3.
// - Loss of external clock sets bit 2.
// - Debug force register takes writes only from background debug.
// - Reads of the debug force register return zero.
// - Debug host writing one to bit 0 forces a reset; zero does nothing.
// - Options one accepts only the first write after each reset.
// - In window mode any status write in the first 75% resets.
module reset_cause_and_debug_reset #(
   parameter int unsigned TICK_DIV    = reset_ctrl_pkg::SLOW_TICK_DIV,
   parameter int unsigned HOLD_CYCLES = reset_ctrl_pkg::RESET_HOLD_CYCLES
) (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire reset_ctrl_pkg::bus_req_t bus,
   output logic [7:0]                    rdata,
   input  wire logic                     low_voltage_reset_enable,
   input  wire logic                     low_voltage_detect,
   input  wire logic                     reset_pin_n,
   input  wire logic                     clock_lost,
   input  wire logic                     illegal_opcode,
   input  wire logic                     stop_executed,
   input  wire logic                     background_instruction,
   input  wire logic                     background_mode_enable,
   input  wire logic                     illegal_address,
   input  wire logic                     watchdog_window_select,
   input  wire logic                     watchdog_clock_bus,
   output logic                          chip_reset,
   output logic [7:0]                    reset_cause_status,
   output logic [7:0]                    system_options_one
);
   localparam int unsigned CW = reset_ctrl_pkg::WD_COUNT_W;
   localparam int unsigned HW = (HOLD_CYCLES > 1) ? $clog2(HOLD_CYCLES) : 1;
   localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES - 1);

   reset_ctrl_pkg::seq_state_t state_r;
   reset_ctrl_pkg::seq_state_t state_nxt;
   logic [HW-1:0] hold_cnt_r;
   logic [HW-1:0] hold_cnt_nxt;
   logic [7:0]    status_r;
   logic [7:0]    status_nxt;
   logic [7:0]    options_r;
   logic [7:0]    options_nxt;
   logic          written_r;
   logic          written_nxt;
   logic          armed_r;
   logic          armed_nxt;
   logic [7:0]    rdata_r;
   logic [7:0]    rdata_nxt;

   logic          slow_tick;
   logic          wd_enable;
   logic          wd_step;
   logic          wd_clear;
   logic          wd_timeout;
   logic [CW-1:0] wd_count;
   logic [CW-1:0] wd_limit;
   logic          window_open;
   logic [4:0]    wd_shift;

   logic          wr_status;
   logic          wr_options;
   logic          wr_debug_force;
   logic          bad_value;
   logic          early_write;
   logic          svc_clear;
   logic          wd_fault;
   logic          bad_op;
   logic          low_trip;
   logic          pin_src;
   logic          any_src;
   logic          entry;

   tick_divider #(
      .DIV (TICK_DIV)
   ) u_tick (
      .clk  (clk),
      .rst  (rst),
      .tick (slow_tick)
   );

   watchdog_counter #(
      .W (CW)
   ) u_wd (
      .clk     (clk),
      .rst     (rst),
      .clear   (wd_clear),
      .step    (wd_step),
      .limit   (wd_limit),
      .count   (wd_count),
      .timeout (wd_timeout)
   );

   // Timeout selection from the options timeout field and the clock source.
   always_comb begin
      wd_enable = options_r[reset_ctrl_pkg::OPT_TIMEOUT_HI:
                            reset_ctrl_pkg::OPT_TIMEOUT_LO] != 2'b00;
      unique case ({watchdog_clock_bus,
                    options_r[reset_ctrl_pkg::OPT_TIMEOUT_HI:
                              reset_ctrl_pkg::OPT_TIMEOUT_LO]})
         3'b000:  wd_shift = reset_ctrl_pkg::SLOW_SHIFT1;
         3'b001:  wd_shift = reset_ctrl_pkg::SLOW_SHIFT1;
         3'b010:  wd_shift = reset_ctrl_pkg::SLOW_SHIFT2;
         3'b011:  wd_shift = reset_ctrl_pkg::SLOW_SHIFT3;
         3'b100:  wd_shift = reset_ctrl_pkg::BUS_SHIFT1;
         3'b101:  wd_shift = reset_ctrl_pkg::BUS_SHIFT1;
         3'b110:  wd_shift = reset_ctrl_pkg::BUS_SHIFT2;
         3'b111:  wd_shift = reset_ctrl_pkg::BUS_SHIFT3;
      endcase
      wd_limit    = CW'(1) << wd_shift;
      // The window opens once three quarters of the period have passed.
      window_open = wd_count >= (wd_limit - (wd_limit >> 2));
      wd_step     = wd_enable && (watchdog_clock_bus || slow_tick);
   end

   // Request decode and reset sources.
   always_comb begin
      wr_status   = bus.wr && (bus.sel == reset_ctrl_pkg::SEL_STATUS);
      wr_options  = bus.wr && (bus.sel == reset_ctrl_pkg::SEL_OPTIONS);
      // User-program writes to the debug register fall through unused.
      wr_debug_force = bus.wr && bus.debug &&
                       (bus.sel == reset_ctrl_pkg::SEL_DEBUG) &&
                       bus.wdata[reset_ctrl_pkg::DEBUG_FORCE_BIT];
      bad_value   = wr_status && wd_enable &&
                    (bus.wdata != reset_ctrl_pkg::SERVICE_FIRST) &&
                    (bus.wdata != reset_ctrl_pkg::SERVICE_SECOND);
      early_write = wr_status && wd_enable && watchdog_window_select &&
                    !window_open;
      wd_fault    = wd_enable &&
                    (wd_timeout || bad_value || early_write);
      bad_op      = illegal_opcode ||
                    (stop_executed &&
                     !options_r[reset_ctrl_pkg::OPT_STOP_ENABLE]) ||
                    (background_instruction &&
                     !background_mode_enable);
      low_trip    = low_voltage_reset_enable && low_voltage_detect;
      pin_src     = !reset_pin_n;
      any_src     = low_trip || wd_fault || bad_op || illegal_address ||
                    clock_lost || pin_src || wr_debug_force;
      entry       = (state_r == reset_ctrl_pkg::ST_RUN) && any_src;
      svc_clear   = wr_status && armed_r && !entry &&
                    (bus.wdata == reset_ctrl_pkg::SERVICE_SECOND);
      // Counting stops while the chip is held in reset or disabled.
      wd_clear    = svc_clear || !wd_enable ||
                    (state_r == reset_ctrl_pkg::ST_HOLD);
   end

   // Reset sequencing: hold the chip reset for a fixed number of cycles.
   always_comb begin
      state_nxt    = state_r;
      hold_cnt_nxt = hold_cnt_r;
      unique case (state_r)
         reset_ctrl_pkg::ST_RUN: begin
            if (entry) begin
               state_nxt    = reset_ctrl_pkg::ST_HOLD;
               hold_cnt_nxt = '0;
            end
         end
         reset_ctrl_pkg::ST_HOLD: begin
            if (hold_cnt_r == HOLD_LAST) begin
               state_nxt = reset_ctrl_pkg::ST_RUN;
            end else begin
               hold_cnt_nxt = hold_cnt_r + HW'(1);
            end
         end
      endcase
   end

   // Cause flags are written only at reset entry; bus writes never reach them.
   always_comb begin
      status_nxt = status_r;
      if (entry) begin
         if (low_trip) begin
            status_nxt = '0;
            status_nxt[reset_ctrl_pkg::BIT_POWER_ON] =
               status_r[reset_ctrl_pkg::BIT_POWER_ON];
            status_nxt[reset_ctrl_pkg::BIT_LOW_VOLTAGE] = 1'b1;
         end else begin
            // The debug force contributes no flag of its own.
            status_nxt = '0;
            status_nxt[reset_ctrl_pkg::BIT_PIN]         = pin_src;
            status_nxt[reset_ctrl_pkg::BIT_WATCHDOG]    = wd_fault;
            status_nxt[reset_ctrl_pkg::BIT_BAD_OPCODE]  = bad_op;
            status_nxt[reset_ctrl_pkg::BIT_BAD_ADDRESS] =
               illegal_address;
            status_nxt[reset_ctrl_pkg::BIT_CLOCK_LOSS]  = clock_lost;
         end
      end
   end

   // Watchdog service sequence and write-once options.
   always_comb begin
      armed_nxt   = armed_r;
      options_nxt = options_r;
      written_nxt = written_r;
      if (state_r == reset_ctrl_pkg::ST_HOLD) begin
         armed_nxt   = 1'b0;
         options_nxt = reset_ctrl_pkg::OPTIONS_RESET;
         written_nxt = 1'b0;
      end else begin
         if (wr_status) begin
            armed_nxt = (bus.wdata == reset_ctrl_pkg::SERVICE_FIRST);
         end
         if (wr_options && !written_r) begin
            options_nxt = bus.wdata & reset_ctrl_pkg::OPTIONS_MASK;
            written_nxt = 1'b1;
         end
      end
   end

   // Read data is registered one cycle after the read strobe.
   always_comb begin
      rdata_nxt = rdata_r;
      if (bus.rd) begin
         unique case (bus.sel)
            reset_ctrl_pkg::SEL_STATUS:
               rdata_nxt = status_r & reset_ctrl_pkg::STATUS_READ_MASK;
            reset_ctrl_pkg::SEL_DEBUG:
               rdata_nxt = reset_ctrl_pkg::DEBUG_READ_VALUE;
            reset_ctrl_pkg::SEL_OPTIONS:
               rdata_nxt = options_r;
            reset_ctrl_pkg::SEL_NONE:
               rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r    <= reset_ctrl_pkg::ST_RUN;
         hold_cnt_r <= '0;
         status_r   <= reset_ctrl_pkg::STATUS_POR_VALUE;
         options_r  <= reset_ctrl_pkg::OPTIONS_RESET;
         written_r  <= 1'b0;
         armed_r    <= 1'b0;
         rdata_r    <= 8'h00;
      end else begin
         state_r    <= state_nxt;
         hold_cnt_r <= hold_cnt_nxt;
         status_r   <= status_nxt;
         options_r  <= options_nxt;
         written_r  <= written_nxt;
         armed_r    <= armed_nxt;
         rdata_r    <= rdata_nxt;
      end
   end

   assign chip_reset         = (state_r == reset_ctrl_pkg::ST_HOLD);
   assign rdata              = rdata_r;
   assign reset_cause_status = status_r & reset_ctrl_pkg::STATUS_READ_MASK;
   assign system_options_one = options_r;

   a_por_flags: assert property (@(posedge clk)
      $past(rst) && !rst |-> status_r == 8'h82)
      else $error("power-on flags wrong after reset");

   a_status_readonly: assert property (@(posedge clk) disable iff (rst)
      !entry |=> $stable(status_r))
      else $error("status changed without a reset entry");

   a_bit0_reads_zero: assert property (@(posedge clk) disable iff (rst)
      bus.rd && bus.sel == reset_ctrl_pkg::SEL_STATUS |=> rdata[0] == 1'b0)
      else $error("status bit 0 read as one");

   a_debug_reads_zero: assert property (@(posedge clk) disable iff (rst)
      bus.rd && bus.sel == reset_ctrl_pkg::SEL_DEBUG |=> rdata == 8'h00)
      else $error("debug register read not zero");

   a_debug_force_clear: assert property (@(posedge clk) disable iff (rst)
      state_r == reset_ctrl_pkg::ST_RUN && wr_debug_force && !low_trip &&
      !wd_fault && !bad_op && !illegal_address && !clock_lost && !pin_src
      |=> chip_reset && status_r == 8'h00 ##1 chip_reset)
      else $error("debug forced reset left a flag or did not reset");

   a_user_debug_ignored: assert property (@(posedge clk) disable iff (rst)
      state_r == reset_ctrl_pkg::ST_RUN && !any_src && bus.wr && !bus.debug
      && bus.sel == reset_ctrl_pkg::SEL_DEBUG |=> !chip_reset)
      else $error("user write to debug register caused a reset");

   a_bad_value_reset: assert property (@(posedge clk) disable iff (rst)
      state_r == reset_ctrl_pkg::ST_RUN && wr_status && wd_enable &&
      bus.wdata != 8'h55 && bus.wdata != 8'haa && !low_trip
      |=> chip_reset && status_r[5])
      else $error("bad service value did not cause a watchdog reset");

   a_service_clear: assert property (@(posedge clk) disable iff (rst)
      state_r == reset_ctrl_pkg::ST_RUN && !any_src && wr_status &&
      bus.wdata == 8'haa && armed_r |=> wd_count == '0 && $stable(status_r))
      else $error("service sequence did not clear the watchdog");

   a_lone_second_kept: assert property (@(posedge clk) disable iff (rst)
      state_r == reset_ctrl_pkg::ST_RUN && !any_src && wr_status &&
      bus.wdata == 8'haa && !armed_r && wd_enable && wd_count != '0
      |=> wd_count != '0)
      else $error("lone second service value cleared the watchdog");

   a_low_voltage_keep: assert property (@(posedge clk) disable iff (rst)
      entry && low_trip |=> status_r[1] && status_r[6:2] == 5'h00 &&
      status_r[7] == $past(status_r[7]))
      else $error("low-voltage reset flags wrong");

   a_wd_disabled: assert property (@(posedge clk) disable iff (rst)
      entry && !wd_enable |=> !status_r[reset_ctrl_pkg::BIT_WATCHDOG])
      else $error("watchdog reset while disabled");

   a_options_once: assert property (@(posedge clk) disable iff (rst)
      written_r && state_r == reset_ctrl_pkg::ST_RUN &&
      state_nxt == reset_ctrl_pkg::ST_RUN |=> $stable(options_r))
      else $error("options changed after the first write");

   a_early_write_reset: assert property (@(posedge clk) disable iff (rst)
      state_r == reset_ctrl_pkg::ST_RUN && wr_status && wd_enable &&
      watchdog_window_select && !window_open |=> chip_reset [*2])
      else $error("early write in window mode did not reset");

   a_pin_flag_set: assert property (@(posedge clk) disable iff (rst)
      entry && !low_trip |=>
      status_r[reset_ctrl_pkg::BIT_PIN] != $past(reset_pin_n))
      else $error("pin flag does not match the reset pin");

   a_bad_address_flag: assert property (@(posedge clk) disable iff (rst)
      entry && !low_trip |=>
      status_r[reset_ctrl_pkg::BIT_BAD_ADDRESS] == $past(illegal_address))
      else $error("address flag does not match its source");

   a_clock_loss_flag: assert property (@(posedge clk) disable iff (rst)
      entry && !low_trip |=>
      status_r[reset_ctrl_pkg::BIT_CLOCK_LOSS] == $past(clock_lost))
      else $error("clock-loss flag does not match its source");

endmodule : reset_cause_and_debug_reset
`default_nettype wire

// [inc/reset_ctrl_pkg.sv]
// Shared constants, field positions and types of the reset-cause block.
package reset_ctrl_pkg;

   // Clock rate and the slow watchdog time base.
   localparam int unsigned CLK_MHZ           = 125;
   localparam int unsigned SLOW_TICK_US      = 1000;
   localparam int unsigned SLOW_TICK_DIV     = SLOW_TICK_US * CLK_MHZ;
   localparam int unsigned RESET_HOLD_CYCLES = 8;

   // Reset-cause status field positions.
   localparam int unsigned BIT_POWER_ON    = 7;
   localparam int unsigned BIT_PIN         = 6;
   localparam int unsigned BIT_WATCHDOG    = 5;
   localparam int unsigned BIT_BAD_OPCODE  = 4;
   localparam int unsigned BIT_BAD_ADDRESS = 3;
   localparam int unsigned BIT_CLOCK_LOSS  = 2;
   localparam int unsigned BIT_LOW_VOLTAGE = 1;
   localparam logic [7:0]  STATUS_POR_VALUE = 8'h82;
   localparam logic [7:0]  STATUS_READ_MASK = 8'hfe;

   // Watchdog service values.
   localparam logic [7:0]  SERVICE_FIRST  = 8'h55;
   localparam logic [7:0]  SERVICE_SECOND = 8'haa;

   // Debug force register.
   localparam int unsigned DEBUG_FORCE_BIT  = 0;
   localparam logic [7:0]  DEBUG_READ_VALUE = 8'h00;

   // System options one: timeout select, stop enable, pin select.
   localparam logic [7:0]  OPTIONS_RESET     = 8'h00;
   localparam logic [7:0]  OPTIONS_MASK      = 8'he8;
   localparam int unsigned OPT_TIMEOUT_HI    = 7;
   localparam int unsigned OPT_TIMEOUT_LO    = 6;
   localparam int unsigned OPT_STOP_ENABLE   = 5;

   // Watchdog counter and timeout exponents.
   localparam int unsigned WD_COUNT_W  = 19;
   localparam logic [4:0]  SLOW_SHIFT1 = 5'h05;
   localparam logic [4:0]  SLOW_SHIFT2 = 5'h08;
   localparam logic [4:0]  SLOW_SHIFT3 = 5'h0a;
   localparam logic [4:0]  BUS_SHIFT1  = 5'h0d;
   localparam logic [4:0]  BUS_SHIFT2  = 5'h10;
   localparam logic [4:0]  BUS_SHIFT3  = 5'h12;

   typedef enum logic [1:0] {
      SEL_NONE    = 2'b00,
      SEL_STATUS  = 2'b01,
      SEL_DEBUG   = 2'b10,
      SEL_OPTIONS = 2'b11
   } reg_sel_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      reg_sel_t   sel;
      logic [7:0] wdata;
      logic       debug;
   } bus_req_t;

   typedef enum logic {
      ST_RUN  = 1'b0,
      ST_HOLD = 1'b1
   } seq_state_t;

endpackage : reset_ctrl_pkg

// [rtl/tick_divider.sv]
// Free-running divider that gives a one-cycle enable pulse every DIV clocks.
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
   parameter int unsigned DIV = 125000
) (
   input  wire logic clk,
   input  wire logic rst,
   output logic      tick
);
   localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   always_comb begin
      cnt_nxt = (cnt_r == LAST) ? '0 : cnt_r + W'(1);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign tick = (cnt_r == LAST);
endmodule : tick_divider
`default_nettype wire

// [rtl/watchdog_counter.sv]
// Watchdog up-counter with clear, step enable and a selectable limit.
`timescale 1ns/100ps
`default_nettype none
module watchdog_counter #(
   parameter int unsigned W = 19
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         clear,
   input  wire logic         step,
   input  wire logic [W-1:0] limit,
   output logic [W-1:0]      count,
   output logic              timeout
);
   logic [W-1:0] count_r;
   logic [W-1:0] count_nxt;

   always_comb begin
      if (clear) begin
         count_nxt = '0;
      end else if (step) begin
         count_nxt = count_r + W'(1);
      end else begin
         count_nxt = count_r;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         count_r <= '0;
      end else begin
         count_r <= count_nxt;
      end
   end

   // The timeout fires on the step that would reach the limit.
   assign timeout = step && !clear && (count_r == limit - W'(1));
   assign count   = count_r;
endmodule : watchdog_counter
`default_nettype wire

// [sim/debug_host_model.sv]
// Behavioural debug host that issues serial background writes.
`timescale 1ns/100ps
`default_nettype none
module debug_host_model (
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    start,
   input  wire logic [7:0]              value,
   output var reset_ctrl_pkg::bus_req_t req
);
   // A background write reaches the block as one debug-tagged write cycle.
   always @(posedge clk) begin
      if (!rst && start) begin
         req <= {1'b1, 1'b0, reset_ctrl_pkg::SEL_DEBUG,
                 value, 1'b1};
      end else begin
         req <= {1'b0, 1'b0, reset_ctrl_pkg::SEL_NONE, ~value, 1'b0};
      end
   end
endmodule : debug_host_model
`default_nettype wire

// [sim/reset_cause_and_debug_reset_test.sv]
// Self-checking testbench of the reset-cause and debug reset block.
`timescale 1ns/100ps
`default_nettype none
module reset_cause_and_debug_reset_test;
   logic                     clk, rst, lvre, bge, wsel, wclk, hstart;
   logic                     chip_reset;
   logic [7:0]               src, hval, rdata, reset_cause_status, opts;
   reset_ctrl_pkg::bus_req_t ub, hreq, bus;
   logic [7:0]               v, d;
   int                       r, checked, miscompares;

   // The host only owns the bus during its own write cycle.
   assign bus = (hreq.wr === 1'b1) ? hreq : ub;

   always #4 clk = ~clk;

   debug_host_model i_debug_host_model (
      .clk(clk), .rst(rst), .start(hstart), .value(hval), .req(hreq));

   reset_cause_and_debug_reset #(.TICK_DIV(8), .HOLD_CYCLES(8))
   i_reset_cause_and_debug_reset (
      .clk                      (clk),
      .rst                      (rst),
      .bus                      (bus),
      .rdata                    (rdata),
      .low_voltage_reset_enable (lvre),
      .low_voltage_detect       (src[1]),
      .reset_pin_n              (~src[6]),
      .clock_lost               (src[2]),
      .illegal_opcode           (src[4]),
      .stop_executed            (src[5]),
      .background_instruction   (src[0]),
      .background_mode_enable   (bge),
      .illegal_address          (src[3]),
      .watchdog_window_select   (wsel),
      .watchdog_clock_bus       (wclk),
      .chip_reset               (chip_reset),
      .reset_cause_status       (reset_cause_status),
      .system_options_one       (opts)
   );

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clk) #1;
   endtask : tick

   task automatic bus_wr(input reset_ctrl_pkg::reg_sel_t s,
                         input logic [7:0] x);
      ub = {1'b1, 1'b0, s, x, 1'b0};
      tick(1);
      ub = {1'b0, 1'b0, reset_ctrl_pkg::SEL_NONE, ~x, 1'b0};
      tick(1);
   endtask : bus_wr

   task automatic bus_rd(input reset_ctrl_pkg::reg_sel_t s,
                         output logic [7:0] x);
      ub = {1'b0, 1'b1, s, 8'h00, 1'b0};
      tick(1);
      ub = '0;
      x = rdata;
      tick(1);
   endtask : bus_rd

   task automatic host_wr(input logic [7:0] x);
      hstart = 1'b1;
      hval = x;
      tick(1);
      hstart = 1'b0;
      tick(2);
   endtask : host_wr

   task automatic pulse(input logic [7:0] s);
      src = s;
      tick(1);
      src = 8'h00;
   endtask : pulse

   // Waits a bounded time for a chip reset, then checks the latched cause.
   task automatic expect_reset(input logic want, input logic [7:0] st,
                               input int maxc);
      int n;
      n = 0;
      while (chip_reset !== 1'b1 && n < maxc) begin
         tick(1);
         n++;
      end
      check("chip_reset", {7'h00, want}, {7'h00, chip_reset});
      if (want && chip_reset !== 1'b1) begin
         give_verdict();
      end
      n = 0;
      while (chip_reset !== 1'b0 && n < 20) begin
         tick(1);
         n++;
      end
      if (chip_reset !== 1'b0) begin
         check("chip_reset release", 8'h00, {7'h00, chip_reset});
         give_verdict();
      end
      check("reset_cause_status", st, reset_cause_status);
   endtask : expect_reset

   function automatic logic [7:0] bad_value();
      logic [7:0] x;
      x = 8'($urandom);
      if (x == 8'h55 || x == 8'haa) begin
         x = x ^ 8'h01;
      end
      return x;
   endfunction : bad_value

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      ub = '0;
      src = 8'h00;
      lvre = 1'b0;
      bge = 1'b0;
      wsel = 1'b0;
      wclk = 1'b1;
      hstart = 1'b0;
      hval = 8'h00;
      checked = 0;
      miscompares = 0;
      r = $urandom(73);
      repeat (6) @(posedge clk);
      #1;
      rst = 1'b0;
      check("status", 8'h82, reset_cause_status);
      check("options", 8'h00, opts);
      bus_rd(reset_ctrl_pkg::SEL_STATUS, d);
      check("status read", 8'h82, d);
      bus_wr(reset_ctrl_pkg::SEL_STATUS, bad_value());
      expect_reset(1'b0, 8'h82, 10);
      pulse(8'h02);
      expect_reset(1'b0, 8'h82, 10);
      lvre = 1'b1;
      pulse(8'h02);
      expect_reset(1'b1, 8'h82, 20);
      v = 8'($urandom) & 8'h3f;
      bus_wr(reset_ctrl_pkg::SEL_OPTIONS, v);
      bus_wr(reset_ctrl_pkg::SEL_OPTIONS, ~v & 8'h3f);
      bus_rd(reset_ctrl_pkg::SEL_OPTIONS, d);
      check("options read", v & 8'he8, d);
      bus_wr(reset_ctrl_pkg::SEL_DEBUG, 8'h01);
      expect_reset(1'b0, 8'h82, 10);
      bus_rd(reset_ctrl_pkg::SEL_DEBUG, d);
      check("debug read", 8'h00, d);
      host_wr(8'hfe);
      expect_reset(1'b0, 8'h82, 10);
      host_wr(8'($urandom) | 8'h01);
      expect_reset(1'b1, 8'h00, 20);
      check("options", 8'h00, opts);
      for (int i = 0; i < 8; i++) begin
         r = $urandom_range(15, 1);
         v = {1'b0, r[3], 1'b0, r[2:0], 2'b00};
         pulse(v);
         expect_reset(1'b1, v, 20);
      end
      pulse(8'h20);
      expect_reset(1'b1, 8'h10, 20);
      pulse(8'h01);
      expect_reset(1'b1, 8'h10, 20);
      bge = 1'b1;
      pulse(8'h01);
      expect_reset(1'b0, 8'h10, 10);
      bus_wr(reset_ctrl_pkg::SEL_OPTIONS, 8'h20);
      pulse(8'h20);
      expect_reset(1'b0, 8'h10, 10);
      pulse(8'h42);
      expect_reset(1'b1, 8'h02, 20);
      bus_wr(reset_ctrl_pkg::SEL_OPTIONS, 8'h40);
      bus_wr(reset_ctrl_pkg::SEL_STATUS, bad_value());
      expect_reset(1'b1, 8'h20, 10);
      // Timeout is 8192 cycles; an unpaired 0xaa must not rescue it.
      bus_wr(reset_ctrl_pkg::SEL_OPTIONS, 8'h40);
      tick(6000);
      bus_wr(reset_ctrl_pkg::SEL_STATUS, 8'haa);
      expect_reset(1'b1, 8'h20, 2400);
      bus_wr(reset_ctrl_pkg::SEL_OPTIONS, 8'h40);
      tick(6000);
      bus_wr(reset_ctrl_pkg::SEL_STATUS, 8'h55);
      bus_wr(reset_ctrl_pkg::SEL_STATUS, 8'haa);
      expect_reset(1'b0, 8'h20, 4000);
      expect_reset(1'b1, 8'h20, 8300);
      wsel = 1'b1;
      bus_wr(reset_ctrl_pkg::SEL_OPTIONS, 8'h40);
      bus_wr(reset_ctrl_pkg::SEL_STATUS, 8'h55);
      expect_reset(1'b1, 8'h20, 10);
      // Slow time base: 32 ticks of 8 clocks, so the timeout lands near 256.
      wsel = 1'b0;
      wclk = 1'b0;
      bus_wr(reset_ctrl_pkg::SEL_OPTIONS, 8'h40);
      expect_reset(1'b0, 8'h20, 200);
      expect_reset(1'b1, 8'h20, 100);
      rst = 1'b1;
      tick(2);
      rst = 1'b0;
      check("status after reset", 8'h82, reset_cause_status);
      check("options after reset", 8'h00, opts);
      give_verdict();
   end
endmodule : reset_cause_and_debug_reset_test
`default_nettype wire
